/* File: shared/bmx_pkg.sv */
// package: opcodes, field layouts, reset values and carrier structs for the exec subset
// What this block does
// - branch loads 11-bit immediate into counter low bits
// - counter bits 12:11 come from page latch 4:3
// - branch is unconditional, flags untouched
// - branch takes two instruction cycles
// - literal OR into accumulator, zero flag updated
// - increment file reg, destination bit selects target
// - OR accumulator with file reg, destination selected
// - move file reg to accumulator or itself
// - register move updates zero flag from value
// - accumulator to file reg, flags unchanged
`default_nettype none
package bmx_pkg;
    // 14-bit instruction word layout
    localparam int IW_W          = 14;
    localparam int PC_W          = 13;
    localparam int FA_W          = 7;
    localparam int DAT_W         = 8;
    localparam int BR_LO_W       = 11;
    localparam int PL_HI_POS     = 4;
    localparam int PL_LO_POS     = 3;
    localparam int D_POS         = 7;
    // opcode patterns
    localparam logic [2:0] OPC_BRANCH   = 3'h5;       // 101k_kkkk_kkkk_kk
    localparam logic [5:0] OPC_OR_LIT   = 6'h38;      // 11_1000_kkkk_kkkk
    localparam logic [5:0] OPC_INC      = 6'h0A;      // 00_1010_dfff_ffff
    localparam logic [5:0] OPC_OR_FILE  = 6'h04;      // 00_0100_dfff_ffff
    localparam logic [5:0] OPC_MOVE_F   = 6'h08;      // 00_1000_dfff_ffff
    localparam logic [6:0] OPC_MOVE_W   = 7'h01;      // 00_0000_1fff_ffff
    // reset values
    localparam logic [12:0] PC_RST  = 13'h0000;
    localparam logic [7:0]  ACC_RST = 8'h00;
    // branch cost in instruction cycles
    localparam int BRANCH_CYCLES = 2;

    typedef enum logic [2:0] {
        OP_NONE, OP_BRANCH, OP_OR_LIT, OP_INC, OP_OR_FILE, OP_MOVE_F, OP_MOVE_W
    } bmx_op_t;

    // instruction issue request
    typedef struct packed {
        logic            valid;
        logic [13:0]     word;
    } bmx_instr_t;

    // file register write port
    typedef struct packed {
        logic            we;
        logic [6:0]      addr;
        logic [7:0]      data;
    } bmx_fwr_t;
endpackage : bmx_pkg
`default_nettype wire

/* File: tb/tb.sv */
// testbench: self-checking scenarios for the branch, OR, increment and move executor
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bmx_pkg::*;

    logic        clk        = 1'b0;
    logic        srst       = 1'b1;
    bmx_instr_t  instr      = '0;
    logic [7:0]  page_latch = 8'h00;
    logic [7:0]  file_rdata = 8'h00;
    logic [6:0]  file_raddr;
    bmx_fwr_t    file_wr;
    logic [12:0] pc;
    logic [7:0]  acc;
    logic        zero_flag;
    logic        busy;
    logic [12:0] exp_pc     = 13'h0000;
    logic [7:0]  exp_acc    = 8'h00;
    logic        exp_z      = 1'b0;
    int          n_mismatch = 0;
    int          comparisons = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    bmx_exec bmx_exec_inst (
        .clk        (clk),
        .srst       (srst),
        .instr      (instr),
        .page_latch (page_latch),
        .file_rdata (file_rdata),
        .file_raddr (file_raddr),
        .file_wr    (file_wr),
        .pc         (pc),
        .acc        (acc),
        .zero_flag  (zero_flag),
        .busy       (busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk(input string name, input logic [12:0] e, input logic [12:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic final_report();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    ////////////////////////////////////////////////////////////////////////////
    // one non-branch instruction, then judge every result it affects
    task automatic run(input logic [13:0] w, input logic [7:0] rd, input logic [7:0] ea,
                       input logic ez, input logic ewe, input logic [7:0] ed);
        @(posedge clk);
        instr      <= {1'b1, w};
        file_rdata <= rd;
        @(posedge clk);
        instr      <= '0;
        #1;
        exp_pc  = exp_pc + 13'h0001;
        exp_acc = ea;
        exp_z   = ez;
        chk("pc", exp_pc, pc);
        chk("acc", 13'(ea), 13'(acc));
        chk("zero_flag", 13'(ez), 13'(zero_flag));
        chk("file_raddr", 13'(w[6:0]), 13'(file_raddr));
        chk("file_wr.we", 13'(ewe), 13'(file_wr.we));
        if (ewe) begin
            chk("file_wr.data", 13'(ed), 13'(file_wr.data));
            chk("file_wr.addr", 13'(w[6:0]), 13'(file_wr.addr));
        end
    endtask : run

    // branch, with a request offered in the busy cycle that must be ignored
    task automatic branch(input logic [10:0] k, input logic [7:0] pl);
        int i;
        @(posedge clk);
        instr      <= {1'b1, OPC_BRANCH, k};
        page_latch <= pl;
        @(posedge clk);
        instr      <= {1'b1, OPC_OR_LIT, 8'hFF};
        #1;
        exp_pc = {pl[PL_HI_POS:PL_LO_POS], k};
        chk("pc", exp_pc, pc);
        chk("acc", 13'(exp_acc), 13'(acc));
        chk("zero_flag", 13'(exp_z), 13'(zero_flag));
        chk("file_wr.we", 13'h0000, 13'(file_wr.we));
        chk("busy", 13'h0001, 13'(busy));
        @(posedge clk);
        instr <= '0;
        #1;
        chk("pc_held", exp_pc, pc);
        chk("acc_held", 13'(exp_acc), 13'(acc));
        chk("zero_held", 13'(exp_z), 13'(zero_flag));
        for (i = 0; i < 2 * BRANCH_CYCLES && busy !== 1'b0; i++) begin
            @(posedge clk);
        end
        if (busy !== 1'b0) begin
            n_mismatch++;
            final_report();
        end
    endtask : branch

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_reset();
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk("pc", 13'h0000, pc);
        chk("acc", 13'h0000, 13'(acc));
        chk("zero_flag", 13'h0000, 13'(zero_flag));
        chk("busy", 13'h0000, 13'(busy));
        chk("file_wr.we", 13'h0000, 13'(file_wr.we));
        chk("file_raddr", 13'h0000, 13'(file_raddr));
    endtask : s_reset

    task automatic s_literal_and_store();
        run({OPC_OR_LIT, 8'h00}, 8'h3C, 8'h00, 1'b1, 1'b0, 8'h00);
        run({OPC_MOVE_W, 7'h7F}, 8'h3C, 8'h00, 1'b1, 1'b1, 8'h00);
        run({OPC_OR_LIT, 8'hA5}, 8'h3C, 8'hA5, 1'b0, 1'b0, 8'h00);
        run({OPC_MOVE_W, 7'h00}, 8'h3C, 8'hA5, 1'b0, 1'b1, 8'hA5);
    endtask : s_literal_and_store

    task automatic s_increment();
        run({OPC_INC, 1'b1, 7'h00}, 8'h41, 8'hA5, 1'b0, 1'b1, 8'h42);
        run({OPC_INC, 1'b0, 7'h55}, 8'hFF, 8'h00, 1'b1, 1'b0, 8'h00);
    endtask : s_increment

    task automatic s_or_file();
        run({OPC_OR_FILE, 1'b0, 7'h12}, 8'h0F, 8'h0F, 1'b0, 1'b0, 8'h00);
        run({OPC_OR_FILE, 1'b1, 7'h7F}, 8'hF0, 8'h0F, 1'b0, 1'b1, 8'hFF);
    endtask : s_or_file

    task automatic s_move_file();
        run({OPC_MOVE_F, 1'b0, 7'h21}, 8'h80, 8'h80, 1'b0, 1'b0, 8'h00);
        run({OPC_MOVE_F, 1'b1, 7'h33}, 8'h00, 8'h80, 1'b1, 1'b1, 8'h00);
    endtask : s_move_file

    task automatic s_branch();
        branch(11'h7FF, 8'h18);
        branch(11'h2AA, 8'hE7);
        run({OPC_OR_LIT, 8'h00}, 8'h00, 8'h80, 1'b0, 1'b0, 8'h00);
    endtask : s_branch

    // reset in mid-run with a request offered, then an undecoded word and a literal or
    task automatic s_midrun_reset();
        @(posedge clk);
        instr <= {1'b1, OPC_OR_LIT, 8'h01};
        srst  <= 1'b1;
        repeat (2) @(posedge clk);
        instr <= '0;
        srst  <= 1'b0;
        #1;
        exp_pc  = PC_RST;
        exp_acc = ACC_RST;
        exp_z   = 1'b0;
        chk("pc", exp_pc, pc);
        chk("acc", 13'(exp_acc), 13'(acc));
        chk("zero_flag", 13'h0000, 13'(zero_flag));
        chk("busy", 13'h0000, 13'(busy));
        chk("file_wr.we", 13'h0000, 13'(file_wr.we));
        run(14'h0000, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
        run({OPC_OR_LIT, 8'h5A}, 8'h00, 8'h5A, 1'b0, 1'b0, 8'h00);
    endtask : s_midrun_reset

    // main sequence
    initial begin
        s_reset();
        s_literal_and_store();
        s_increment();
        s_or_file();
        s_move_file();
        s_branch();
        s_midrun_reset();
        final_report();
    end
endmodule : tb
`default_nettype wire

/* File: verilog/bmx_exec.sv */
// design: executes branch, OR, increment and move instructions of an 8-bit core
`default_nettype none
module bmx_exec (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire bmx_pkg::bmx_instr_t  instr,       // instruction issue, valid + word
    input  wire logic [7:0]           page_latch,  // page latch register contents
    input  wire logic [7:0]           file_rdata,  // addressed file reg, combinational read
    output logic [6:0]                file_raddr,  // file read address (registered mirror)
    output bmx_pkg::bmx_fwr_t         file_wr,     // file register write
    output logic [12:0]               pc,          // program counter
    output logic [7:0]                acc,         // working accumulator
    output logic                      zero_flag,   // zero status flag
    output logic                      busy         // high in the branch's second cycle
);
    import bmx_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic bmx_op_t decode(input logic [13:0] w);
        bmx_op_t o;
        o = OP_NONE;
        if (w[13:11] == OPC_BRANCH) begin
            o = OP_BRANCH;
        end else if (w[13:8] == OPC_OR_LIT) begin
            o = OP_OR_LIT;
        end else if (w[13:8] == OPC_INC) begin
            o = OP_INC;
        end else if (w[13:8] == OPC_OR_FILE) begin
            o = OP_OR_FILE;
        end else if (w[13:8] == OPC_MOVE_F) begin
            o = OP_MOVE_F;
        end else if (w[13:7] == OPC_MOVE_W) begin
            o = OP_MOVE_W;
        end
        return o;
    endfunction : decode

    // register-operand group whose destination bit picks accumulator or file reg
    function automatic logic dest_op(input bmx_op_t o);
        return (o == OP_INC) || (o == OP_OR_FILE) || (o == OP_MOVE_F);
    endfunction : dest_op

    // instructions that update the zero flag
    function automatic logic flag_op(input bmx_op_t o);
        return (o == OP_OR_LIT) || dest_op(o);
    endfunction : flag_op

    bmx_op_t     op;
    logic        take;
    logic        dbit;
    logic [7:0]  res;
    logic [6:0]  faddr;

    // instructions are refused while the branch occupies its second cycle
    assign take  = instr.valid && !busy;
    assign op    = take ? decode(instr.word) : OP_NONE;
    assign dbit  = instr.word[D_POS];
    assign faddr = instr.word[FA_W-1:0];

    // alu result
    always_comb begin
        res = 8'h00;
        case (op)
            OP_OR_LIT:  res = acc | instr.word[DAT_W-1:0];
            OP_INC:     res = file_rdata + 8'h01;
            OP_OR_FILE: res = acc | file_rdata;
            OP_MOVE_F:  res = file_rdata;
            OP_MOVE_W:  res = acc;
            default:    res = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter and branch stall

    // branch builds the counter; other instructions advance by one
    always_ff @(posedge clk) begin
        if (srst) begin
            pc <= PC_RST;
        end else if (op == OP_BRANCH) begin
            pc <= {page_latch[PL_HI_POS:PL_LO_POS],
                   instr.word[BR_LO_W-1:0]};
        end else if (take) begin
            pc <= pc + 13'h0001;
        end
    end

    // second instruction cycle of the branch
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= (op == OP_BRANCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator and zero flag

    // destination bit 0 or literal OR goes to the accumulator
    always_ff @(posedge clk) begin
        if (srst) begin
            acc <= ACC_RST;
        end else if (op == OP_OR_LIT) begin
            acc <= res;
        end else if (dest_op(op) && !dbit) begin
            acc <= res;
        end
    end

    // zero flag follows the 8-bit result of the flag-affecting group
    always_ff @(posedge clk) begin
        if (srst) begin
            zero_flag <= 1'b0;
        end else if (flag_op(op)) begin
            zero_flag <= (res == 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // file register write port

    // write strobe, address and data, plus the read address mirror
    always_ff @(posedge clk) begin
        if (srst) begin
            file_wr    <= '0;
            file_raddr <= 7'h00;
        end else begin
            file_raddr   <= faddr;
            file_wr.addr <= faddr;
            file_wr.data <= res;
            file_wr.we   <= (op == OP_MOVE_W) || (dest_op(op) && dbit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_branch_pc;
        @(posedge clk) disable iff (srst)
        (op == OP_BRANCH) |=> pc == {$past(page_latch[PL_HI_POS:PL_LO_POS]),
                                     $past(instr.word[BR_LO_W-1:0])};
    endproperty
    a_branch_pc: assert property (p_branch_pc) else $error("branch target wrong");

    property p_branch_hi;
        @(posedge clk) disable iff (srst)
        (op == OP_BRANCH) |=> pc[PC_W-1:BR_LO_W] == $past(page_latch[PL_HI_POS:PL_LO_POS]);
    endproperty
    a_branch_hi: assert property (p_branch_hi) else $error("branch page bits wrong");

    property p_branch_flags;
        @(posedge clk) disable iff (srst)
        (op == OP_BRANCH) |=> $stable(zero_flag) && $stable(acc) && !file_wr.we;
    endproperty
    a_branch_flags: assert property (p_branch_flags) else $error("branch touched state");

    property p_branch_two;
        @(posedge clk) disable iff (srst)
        (op == OP_BRANCH) |=> busy ##1 !busy;
    endproperty
    a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

    property p_or_lit;
        @(posedge clk) disable iff (srst)
        (op == OP_OR_LIT) |=> acc == ($past(acc) | $past(instr.word[DAT_W-1:0]));
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("literal or wrong");

    property p_inc;
        @(posedge clk) disable iff (srst)
        (op == OP_INC && dbit) |=> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("increment write wrong");

    property p_or_file;
        @(posedge clk) disable iff (srst)
        (op == OP_OR_FILE && !dbit) |=> acc == ($past(acc) | $past(file_rdata)) && !file_wr.we;
    endproperty
    a_or_file: assert property (p_or_file) else $error("file or wrong");

    property p_move_f;
        @(posedge clk) disable iff (srst)
        (op == OP_MOVE_F && !dbit) |=> acc == $past(file_rdata);
    endproperty
    a_move_f: assert property (p_move_f) else $error("file move wrong");

    property p_move_z;
        @(posedge clk) disable iff (srst)
        (op == OP_MOVE_F) |=> zero_flag == ($past(file_rdata) == 8'h00);
    endproperty
    a_move_z: assert property (p_move_z) else $error("move zero flag wrong");

    property p_move_w;
        @(posedge clk) disable iff (srst)
        (op == OP_MOVE_W) |=> file_wr.we && file_wr.data == $past(acc) && $stable(zero_flag);
    endproperty
    a_move_w: assert property (p_move_w) else $error("acc move wrong");

    property p_zero;
        @(posedge clk) disable iff (srst)
        flag_op(op) |=> zero_flag == ((file_wr.we ? file_wr.data : acc) == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

    // destination selection, write port, zero flag, counter, reset and refusal checks
    property p_refused;
        @(posedge clk) disable iff (srst)
        (busy && instr.valid) |=> $stable(pc) && $stable(acc) && $stable(zero_flag) &&
                                  !file_wr.we;
    endproperty
    a_refused: assert property (p_refused) else $error("request taken while busy");

    property p_busy_src;
        @(posedge clk) disable iff (srst)
        busy |-> $past(op == OP_BRANCH);
    endproperty
    a_busy_src: assert property (p_busy_src) else $error("busy without branch");

    property p_pc_step;
        @(posedge clk) disable iff (srst)
        (take && op != OP_BRANCH) |=> pc == $past(pc) + 13'h0001;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter did not step");

    property p_inc_acc;
        @(posedge clk) disable iff (srst)
        (op == OP_INC && !dbit) |=> (acc == $past(file_rdata) + 8'h01) && !file_wr.we;
    endproperty
    a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

    property p_inc_z;
        @(posedge clk) disable iff (srst)
        (op == OP_INC) |=> zero_flag == (($past(file_rdata) + 8'h01) == 8'h00);
    endproperty
    a_inc_z: assert property (p_inc_z) else $error("increment flag wrong");

    property p_dest0_nowr;
        @(posedge clk) disable iff (srst)
        (dest_op(op) && !dbit) |=> !file_wr.we;
    endproperty
    a_dest0_nowr: assert property (p_dest0_nowr) else $error("unexpected write");

    property p_or_file_wr;
        @(posedge clk) disable iff (srst)
        (op == OP_OR_FILE && dbit) |=> file_wr.we && $stable(acc) &&
                                       file_wr.data == ($past(acc) | $past(file_rdata));
    endproperty
    a_or_file_wr: assert property (p_or_file_wr) else $error("file or write wrong");

    property p_or_file_z;
        @(posedge clk) disable iff (srst)
        (op == OP_OR_FILE) |=> zero_flag == (($past(acc) | $past(file_rdata)) == 8'h00);
    endproperty
    a_or_file_z: assert property (p_or_file_z) else $error("file or flag wrong");

    property p_or_lit_z;
        @(posedge clk) disable iff (srst)
        (op == OP_OR_LIT) |=> zero_flag == (acc == 8'h00) && !file_wr.we;
    endproperty
    a_or_lit_z: assert property (p_or_lit_z) else $error("literal or flag wrong");

    property p_move_f_wr;
        @(posedge clk) disable iff (srst)
        (op == OP_MOVE_F && dbit) |=> file_wr.we && $stable(acc) &&
                                      file_wr.data == $past(file_rdata);
    endproperty
    a_move_f_wr: assert property (p_move_f_wr) else $error("file move write wrong");

    property p_move_w_keep;
        @(posedge clk) disable iff (srst)
        (op == OP_MOVE_W) |=> $stable(acc) && file_wr.addr == $past(faddr);
    endproperty
    a_move_w_keep: assert property (p_move_w_keep) else $error("acc move addr wrong");

    property p_write_src;
        @(posedge clk) disable iff (srst)
        file_wr.we |-> $past(op == OP_MOVE_W || (dest_op(op) && dbit));
    endproperty
    a_write_src: assert property (p_write_src) else $error("spurious file write");

    property p_raddr;
        @(posedge clk) disable iff (srst)
        instr.valid |=> file_raddr == $past(faddr);
    endproperty
    a_raddr: assert property (p_raddr) else $error("read address mirror wrong");

    property p_zero_hold;
        @(posedge clk) disable iff (srst)
        ($changed(zero_flag) && !$past(srst)) |-> $past(flag_op(op));
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("zero flag moved alone");

    property p_reset_state;
        @(posedge clk)
        srst |=> pc == PC_RST && acc == ACC_RST && !zero_flag && !busy && !file_wr.we;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");


    // cover points for the main scenarios
    c_branch: cover property (@(posedge clk) disable iff (srst) op == OP_BRANCH ##1 busy);
    c_inc_wrap: cover property (@(posedge clk) disable iff (srst)
        op == OP_INC && file_rdata == 8'hFF);
    c_move_test: cover property (@(posedge clk) disable iff (srst) op == OP_MOVE_F && dbit);
    c_refused: cover property (@(posedge clk) disable iff (srst) busy && instr.valid);
    c_move_w: cover property (@(posedge clk) disable iff (srst)
        op == OP_MOVE_W ##1 file_wr.we);
endmodule : bmx_exec
`default_nettype wire
